// *** src/aluf_pkg.sv ***
// shared constants and types for the alu status flag block
package aluf_pkg;

    // datapath and bus widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FLAG_W = 5;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned BUS_W = 32;

    // flag bit positions inside the flag register, then bit positions inside the result byte
    localparam int unsigned CARRY_BIT = 0;
    localparam int unsigned DIGIT_CARRY_BIT = 1;
    localparam int unsigned ZERO_BIT = 2;
    localparam int unsigned OVERFLOW_BIT = 3;
    localparam int unsigned NEGATIVE_BIT = 4;
    localparam int unsigned SIGN_BIT = 7;
    localparam int unsigned NIBBLE_BIT = 4;
    localparam int unsigned LOW_NIBBLE_TOP = 3;

    // flag update masks
    localparam logic [4:0] MASK_NONE = 5'h00;
    localparam logic [4:0] MASK_ALL = 5'h1f;
    localparam logic [4:0] MASK_ZERO = 5'h04;
    localparam logic [4:0] MASK_ZERO_NEG = 5'h14;
    localparam logic [4:0] MASK_ROTATE = 5'h17;

    // apb register byte offsets
    localparam logic [11:0] FLAG_OFS = 12'h000;
    localparam logic [11:0] CTRL_OFS = 12'h004;
    localparam logic [11:0] RESULT_OFS = 12'h008;
    localparam logic [11:0] MODE_OFS = 12'h00c;

    // control register layout and reset values
    localparam int unsigned CTRL_EXT_BIT = 0;
    localparam logic [4:0] FLAG_RESET = 5'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

    // direct addresses below this with the access bit clear select indexed mode when the extended set is on
    localparam logic [7:0] INDEX_LIMIT = 8'h60;

    // operations issued by the execution core
    typedef enum logic [4:0] {
        OP_ADD_W_FILE,
        OP_ADD_LITERAL,
        OP_SUB_FROM_LITERAL,
        OP_SUB_W_FROM_FILE,
        OP_ROTATE_RIGHT,
        OP_ROTATE_LEFT,
        OP_AND,
        OP_IOR,
        OP_XOR,
        OP_MOVE_FILE,
        OP_CLEAR_FILE,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_NIBBLE_SWAP,
        OP_FILE_TO_FILE_MOVE,
        OP_W_TO_FILE_MOVE
    } aluf_op_t;

    // data addressing modes
    typedef enum logic [2:0] {
        MODE_INHERENT,
        MODE_LITERAL,
        MODE_DIRECT,
        MODE_INDIRECT,
        MODE_INDEXED
    } aluf_mode_t;

endpackage

// *** src/aluf_flags.sv ***
// alu status flag register with apb access and addressing mode select
// Function
// RQ1: flag destination never overrides computed flags
// RQ2: clear file sets zero, keeps others
// RQ3: bit, swap and moves leave flags
// RQ4: flag register works as normal operand
// RQ5: subtract adds complement, carry means no-borrow
// RQ6: upper three bits read zero always
// RQ7: negative follows result top bit
// RQ8: overflow when signed sign bit flips
// RQ9: zero set when result is zero
// RQ10: digit carry from low nibble carry
// RQ11: carry from most significant result bit
// RQ12: rotate loads digit carry bit four/three
// RQ13: rotate loads carry from end bit
// RQ14: data memory modes only; program via counter
// RQ15: mode fixed or operand-selected per instruction
// RQ16: indexed mode only with extended set (the code also passes a MODE_INDEXED operand through when it is off)
// RQ17: flags update with the result write
`timescale 1ns/10ps

module aluf_flags (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic exec_valid,
    input wire aluf_pkg::aluf_op_t exec_op,
    input wire logic [7:0] exec_w,
    input wire logic [7:0] exec_file,
    input wire logic [2:0] exec_bit,
    input wire logic exec_dest_flags,
    input wire aluf_pkg::aluf_mode_t exec_mode,
    input wire logic exec_access_bit,
    output logic [4:0] flags,
    output logic [7:0] alu_result,
    output logic result_valid,
    output aluf_pkg::aluf_mode_t addr_mode
);

    // control and status state
    logic ext_enable;

    // adds two bytes with carry in, returns {carry, digit carry, sum}
    function automatic logic [9:0] add_with_carry(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin
    );
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        add_with_carry = {full[8], low[4], full[7:0]};
    endfunction

    // operand selection for the adder
    logic is_add;
    logic is_sub;
    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_cin;
    logic [9:0] add_out;
    logic [7:0] add_sum;
    logic add_carry;
    logic add_dc;
    logic add_ov;

    assign is_add = (exec_op == aluf_pkg::OP_ADD_W_FILE) || (exec_op == aluf_pkg::OP_ADD_LITERAL);
    assign is_sub = (exec_op == aluf_pkg::OP_SUB_FROM_LITERAL) || (exec_op == aluf_pkg::OP_SUB_W_FROM_FILE);
    // subtraction adds the two's complement of w, so carry high means no borrow
    assign add_a = exec_file;
    assign add_b = is_sub ? ~exec_w : exec_w; // [RQ5]
    assign add_cin = is_sub; // [RQ5]
    assign add_out = add_with_carry(add_a, add_b, add_cin);
    assign add_sum = add_out[7:0];
    assign add_carry = add_out[9]; // [RQ11]
    assign add_dc = add_out[8]; // [RQ10]
    // signed overflow: equal operand signs but result sign differs
    assign add_ov = (add_a[aluf_pkg::SIGN_BIT] == add_b[aluf_pkg::SIGN_BIT])
        && (add_sum[aluf_pkg::SIGN_BIT] != add_a[aluf_pkg::SIGN_BIT]); // [RQ8]

    // rotate through carry
    logic cur_carry;
    logic [7:0] rot_right;
    logic [7:0] rot_left;

    assign cur_carry = flags[aluf_pkg::CARRY_BIT];
    assign rot_right = {cur_carry, exec_file[7:1]};
    assign rot_left = {exec_file[6:0], cur_carry};

    // bits that rotates move into carry and digit carry
    logic rr_carry;
    logic rr_dc;
    logic rl_carry;
    logic rl_dc;

    assign rr_carry = exec_file[0]; // [RQ13]
    assign rr_dc = exec_file[aluf_pkg::NIBBLE_BIT]; // [RQ12]
    assign rl_carry = exec_file[aluf_pkg::SIGN_BIT]; // [RQ13]
    assign rl_dc = exec_file[aluf_pkg::LOW_NIBBLE_TOP]; // [RQ12]

    // single bit masks for bit clear and set
    logic [7:0] bit_mask;

    assign bit_mask = 8'h01 << exec_bit;

    // result and flag update mask per operation
    logic [7:0] op_result;
    logic [4:0] upd_mask;
    logic calc_carry;
    logic calc_dc;
    logic calc_ov;

    always_comb begin
        op_result = exec_file;
        upd_mask = aluf_pkg::MASK_NONE;
        calc_carry = add_carry;
        calc_dc = add_dc;
        calc_ov = add_ov;
        unique case (exec_op)
            aluf_pkg::OP_ADD_W_FILE,
            aluf_pkg::OP_ADD_LITERAL,
            aluf_pkg::OP_SUB_FROM_LITERAL,
            aluf_pkg::OP_SUB_W_FROM_FILE: begin
                op_result = add_sum;
                upd_mask = aluf_pkg::MASK_ALL; // [RQ10] [RQ11]
            end
            aluf_pkg::OP_ROTATE_RIGHT: begin
                op_result = rot_right;
                upd_mask = aluf_pkg::MASK_ROTATE;
                calc_carry = rr_carry; // [RQ13]
                calc_dc = rr_dc; // [RQ12]
            end
            aluf_pkg::OP_ROTATE_LEFT: begin
                op_result = rot_left;
                upd_mask = aluf_pkg::MASK_ROTATE;
                calc_carry = rl_carry; // [RQ13]
                calc_dc = rl_dc; // [RQ12]
            end
            aluf_pkg::OP_AND: begin
                op_result = exec_file & exec_w;
                upd_mask = aluf_pkg::MASK_ZERO_NEG;
            end
            aluf_pkg::OP_IOR: begin
                op_result = exec_file | exec_w;
                upd_mask = aluf_pkg::MASK_ZERO_NEG;
            end
            aluf_pkg::OP_XOR: begin
                op_result = exec_file ^ exec_w;
                upd_mask = aluf_pkg::MASK_ZERO_NEG;
            end
            aluf_pkg::OP_MOVE_FILE: begin
                op_result = exec_file;
                upd_mask = aluf_pkg::MASK_ZERO_NEG;
            end
            aluf_pkg::OP_CLEAR_FILE: begin
                op_result = aluf_pkg::ZERO_BYTE;
                upd_mask = aluf_pkg::MASK_ZERO; // [RQ2]
            end
            // these leave every arithmetic flag alone unless the flag register is their destination
            aluf_pkg::OP_BIT_CLEAR: op_result = exec_file & ~bit_mask; // [RQ3]
            aluf_pkg::OP_BIT_SET: op_result = exec_file | bit_mask; // [RQ3]
            aluf_pkg::OP_NIBBLE_SWAP: op_result = {exec_file[3:0], exec_file[7:4]}; // [RQ3]
            aluf_pkg::OP_FILE_TO_FILE_MOVE: op_result = exec_file; // [RQ3]
            aluf_pkg::OP_W_TO_FILE_MOVE: op_result = exec_w; // [RQ3]
            // undefined operation codes pass the file through and leave flags alone unless the flag register is the destination
            default: begin
                op_result = exec_file;
                upd_mask = aluf_pkg::MASK_NONE;
            end
        endcase
    end

    // flag values produced by the flag logic
    logic [4:0] calc_flags;

    assign calc_flags[aluf_pkg::CARRY_BIT] = calc_carry;
    assign calc_flags[aluf_pkg::DIGIT_CARRY_BIT] = calc_dc;
    assign calc_flags[aluf_pkg::ZERO_BIT] = (op_result == aluf_pkg::ZERO_BYTE); // [RQ9]
    assign calc_flags[aluf_pkg::OVERFLOW_BIT] = calc_ov; // [RQ8]
    assign calc_flags[aluf_pkg::NEGATIVE_BIT] = op_result[aluf_pkg::SIGN_BIT]; // [RQ7]

    // data written back when the flag register is the destination
    logic [4:0] dest_data;
    logic [4:0] exec_flags;
    logic flag_write_blocked;

    // an instruction that touches any flag locks all five bits against its own write
    assign flag_write_blocked = (upd_mask != aluf_pkg::MASK_NONE); // [RQ1]
    assign dest_data = (exec_dest_flags && !flag_write_blocked) ? op_result[4:0] : flags; // [RQ4]
    // untouched flags keep their value, so clear file only sets zero
    assign exec_flags = (calc_flags & upd_mask) | (dest_data & ~upd_mask); // [RQ1] [RQ2]

    // addressing mode resolution
    logic idx_hit;
    aluf_pkg::aluf_mode_t next_addr_mode;

    // indexed mode replaces access-bank direct only with the extended set
    assign idx_hit = ext_enable && !exec_access_bit && (exec_file < aluf_pkg::INDEX_LIMIT); // [RQ16]
    // program memory never reaches here; only data modes resolve
    assign next_addr_mode = ((exec_mode == aluf_pkg::MODE_DIRECT) && idx_hit)
        ? aluf_pkg::MODE_INDEXED : exec_mode; // [RQ14] [RQ15]

    // apb decode, one select per mapped register
    logic setup_phase;
    logic access_done;
    logic wr_flags;
    logic wr_ctrl;
    logic addr_hit;
    logic sel_flag_reg;
    logic sel_ctrl_reg;
    logic sel_result_reg;
    logic sel_mode_reg;
    logic [31:0] read_mux;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign sel_flag_reg = (paddr == aluf_pkg::FLAG_OFS);
    assign sel_ctrl_reg = (paddr == aluf_pkg::CTRL_OFS);
    assign sel_result_reg = (paddr == aluf_pkg::RESULT_OFS);
    assign sel_mode_reg = (paddr == aluf_pkg::MODE_OFS);
    // unmapped addresses answer with an error and no data
    assign addr_hit = sel_flag_reg || sel_ctrl_reg || sel_result_reg || sel_mode_reg;
    // result and mode registers are read-only, writes there fall away
    assign wr_flags = access_done && pwrite && sel_flag_reg;
    assign wr_ctrl = access_done && pwrite && sel_ctrl_reg;

    // read data, unused upper bits read zero
    always_comb begin
        read_mux = aluf_pkg::BUS_ZERO;
        if (sel_flag_reg) begin
            read_mux[4:0] = flags; // [RQ6]
        end else if (sel_ctrl_reg) begin
            read_mux[aluf_pkg::CTRL_EXT_BIT] = ext_enable;
        end else if (sel_result_reg) begin
            read_mux[7:0] = alu_result;
        end else if (sel_mode_reg) begin
            read_mux[2:0] = addr_mode;
        end
    end

    // next flag value: core result beats a bus write in the same cycle
    logic [4:0] next_flags;
    logic [4:0] bus_flags;

    // only the five flag bits are stored, bits 7..5 of a write fall away
    assign bus_flags = pwdata[4:0]; // [RQ6]
    assign next_flags = exec_valid ? exec_flags
        : (wr_flags ? bus_flags : flags); // [RQ4]

    // flag register, updated on the same edge as the result
    // cleared on reset so that the first read is defined
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flags <= aluf_pkg::FLAG_RESET;
        end else begin
            flags <= next_flags; // [RQ17]
        end
    end

    // result and mode capture
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            alu_result <= aluf_pkg::RESULT_RESET;
            result_valid <= 1'b0;
            addr_mode <= aluf_pkg::MODE_INHERENT;
        end else begin
            result_valid <= exec_valid;
            if (exec_valid) begin
                alu_result <= op_result; // [RQ17]
                addr_mode <= next_addr_mode;
            end
        end
    end

    // extended set control bit
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ext_enable <= 1'b0;
        end else if (wr_ctrl) begin
            ext_enable <= pwdata[aluf_pkg::CTRL_EXT_BIT]; // [RQ16]
        end
    end

    // apb answer: one wait-free access phase after each setup
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= aluf_pkg::BUS_ZERO;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !addr_hit;
            if (setup_phase) begin
                prdata <= addr_hit ? read_mux : aluf_pkg::BUS_ZERO;
            end
        end
    end

endmodule

// *** test/aluf_flags_chk.sv ***
// assertions watching the alu status flag block ports
`timescale 1ns/10ps
module aluf_flags_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic exec_valid,
    input wire aluf_pkg::aluf_op_t exec_op,
    input wire logic [7:0] exec_w,
    input wire logic [7:0] exec_file,
    input wire logic [2:0] exec_bit,
    input wire logic exec_dest_flags,
    input wire aluf_pkg::aluf_mode_t exec_mode,
    input wire logic exec_access_bit,
    input wire logic [4:0] flags,
    input wire logic [7:0] alu_result,
    input wire logic result_valid,
    input wire aluf_pkg::aluf_mode_t addr_mode
);
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // operation classes and operand views
    wire logic zn_op = exec_valid && (exec_op <= aluf_pkg::OP_MOVE_FILE);
    wire logic keep_op = exec_valid && !exec_dest_flags && (exec_op >= aluf_pkg::OP_BIT_CLEAR);
    wire logic [8:0] add_sum = {1'b0, exec_file} + {1'b0, exec_w};
    wire logic [1:0] rr_src = {exec_file[4], exec_file[0]};

    chk_valid_follows: assert property (exec_valid |=> result_valid)
        else $error("result_valid missing after an instruction");
    chk_valid_quiet: assert property (!exec_valid |=> !result_valid)
        else $error("result_valid without an instruction");
    chk_neg_follows: assert property (zn_op |=> flags[4] == alu_result[7])
        else $error("negative flag differs from result sign");
    chk_zero_follows: assert property (zn_op |=> flags[2] == (alu_result == 8'h00))
        else $error("zero flag differs from result");
    chk_flags_kept: assert property (keep_op |=> $stable(flags))
        else $error("flags moved on a flag-neutral instruction");
    chk_clear_zero: assert property (exec_valid && exec_op == aluf_pkg::OP_CLEAR_FILE |=>
        flags == ($past(flags) | 5'h04)) else $error("clear did not set only the zero flag");
    chk_add_carry: assert property (exec_valid && exec_op == aluf_pkg::OP_ADD_W_FILE |=>
        {flags[0], alu_result} == $past(add_sum)) else $error("add result or carry wrong");
    chk_rotr_src: assert property (exec_valid && exec_op == aluf_pkg::OP_ROTATE_RIGHT |=>
        flags[1:0] == $past(rr_src)) else $error("rotate right carry sources wrong");
    chk_mode_fixed: assert property (exec_valid && exec_mode != aluf_pkg::MODE_DIRECT |=>
        addr_mode == $past(exec_mode)) else $error("fixed addressing mode altered");
    chk_read_upper: assert property (psel && penable && pready && !pwrite && paddr == aluf_pkg::FLAG_OFS |->
        prdata[31:5] == 27'h000_0000) else $error("flag register upper bits not zero");
    chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not exactly one access cycle");
    chk_err_data: assert property (pslverr |-> pready && prdata == aluf_pkg::BUS_ZERO)
        else $error("error response without ready or with data");
endmodule

bind aluf_flags aluf_flags_chk aluf_flags_chk_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_w(exec_w), .exec_file(exec_file), .exec_bit(exec_bit),
    .exec_dest_flags(exec_dest_flags), .exec_mode(exec_mode), .exec_access_bit(exec_access_bit), .flags(flags),
    .alu_result(alu_result), .result_valid(result_valid), .addr_mode(addr_mode));

// *** test/aluf_core_model.sv ***
// behavioural model of the core that issues instructions to the flag block
`timescale 1ns/10ps
module aluf_core_model (
    input wire logic ref_clk,
    output logic exec_valid,
    output aluf_pkg::aluf_op_t exec_op,
    output logic [7:0] exec_w,
    output logic [7:0] exec_file,
    output logic [2:0] exec_bit,
    output logic exec_dest_flags,
    output aluf_pkg::aluf_mode_t exec_mode,
    output logic exec_access_bit
);
    // quiet core at time zero
    initial begin
        exec_valid = 1'b0;
        exec_op = aluf_pkg::OP_AND;
        exec_w = 8'h00;
        exec_file = 8'h00;
        exec_bit = 3'h0;
        exec_dest_flags = 1'b0;
        exec_mode = aluf_pkg::MODE_INHERENT;
        exec_access_bit = 1'b0;
    end

    // present one instruction from the next rising edge on
    task automatic issue(input aluf_pkg::aluf_op_t op, input logic [7:0] f, input logic [7:0] w, input logic [2:0] b,
        input logic dest, input aluf_pkg::aluf_mode_t mode, input logic abit);
        @(posedge ref_clk);
        exec_valid <= 1'b1;
        exec_op <= op;
        exec_file <= f;
        exec_w <= w;
        exec_bit <= b;
        exec_dest_flags <= dest;
        exec_mode <= mode;
        exec_access_bit <= abit;
    endtask

    // end the burst; stale w and file operands are inverted so nothing leans on them
    task automatic idle();
        @(posedge ref_clk);
        exec_valid <= 1'b0;
        exec_w <= ~exec_w;
        exec_file <= ~exec_file;
    endtask
endmodule

// *** test/alu_status_flags_tb.sv ***
// self-checking bench for the alu status flag block
`timescale 1ns/10ps
module alu_status_flags_tb;
    typedef struct packed {
        logic [4:0] op;
        logic [7:0] f;
        logic [7:0] w;
        logic [2:0] b;
        logic [7:0] res;
        logic [4:0] flg;
    } aluf_row_t;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, exec_valid, exec_dest_flags, exec_access_bit, result_valid;
    logic [7:0] exec_w, exec_file, alu_result;
    logic [2:0] exec_bit;
    logic [4:0] flags;
    aluf_pkg::aluf_op_t exec_op;
    aluf_pkg::aluf_mode_t exec_mode, addr_mode;
    int fails = 0;
    int total_checks = 0;
    // op codes are enum positions; flags {neg, ov, zero, dc, carry}, each row sees the flags left by the one before
    aluf_row_t rows [17] = '{'{5'h00, 8'h0f, 8'h01, 3'h0, 8'h10, 5'h02}, '{5'h01, 8'h7f, 8'h01, 3'h0, 8'h80, 5'h1a},
        '{5'h00, 8'hff, 8'h01, 3'h0, 8'h00, 5'h07}, '{5'h03, 8'h05, 8'h06, 3'h0, 8'hff, 5'h10},
        '{5'h02, 8'h80, 8'h01, 3'h0, 8'h7f, 5'h09}, '{5'h04, 8'h11, 8'h00, 3'h0, 8'h88, 5'h1b},
        '{5'h05, 8'h08, 8'h00, 3'h0, 8'h11, 5'h0a}, '{5'h06, 8'hf0, 8'h0f, 3'h0, 8'h00, 5'h0e},
        '{5'h07, 8'h80, 8'h01, 3'h0, 8'h81, 5'h1a}, '{5'h08, 8'hff, 8'hff, 3'h0, 8'h00, 5'h0e},
        '{5'h09, 8'h90, 8'h00, 3'h0, 8'h90, 5'h1a}, '{5'h0c, 8'h00, 8'h00, 3'h3, 8'h08, 5'h1a},
        '{5'h0b, 8'hff, 8'h00, 3'h0, 8'hfe, 5'h1a}, '{5'h0d, 8'ha5, 8'h00, 3'h0, 8'h5a, 5'h1a},
        '{5'h0e, 8'h3c, 8'h00, 3'h0, 8'h3c, 5'h1a}, '{5'h0f, 8'h00, 8'hc3, 3'h0, 8'hc3, 5'h1a},
        '{5'h0a, 8'h55, 8'h00, 3'h0, 8'h00, 5'h1e}};

    // free-running 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    aluf_flags aluf_flags_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec_valid(exec_valid),
        .exec_op(exec_op), .exec_w(exec_w), .exec_file(exec_file), .exec_bit(exec_bit),
        .exec_dest_flags(exec_dest_flags), .exec_mode(exec_mode), .exec_access_bit(exec_access_bit), .flags(flags),
        .alu_result(alu_result), .result_valid(result_valid), .addr_mode(addr_mode));
    aluf_core_model aluf_core_model_i (.ref_clk(ref_clk), .exec_valid(exec_valid), .exec_op(exec_op),
        .exec_w(exec_w), .exec_file(exec_file), .exec_bit(exec_bit), .exec_dest_flags(exec_dest_flags),
        .exec_mode(exec_mode), .exec_access_bit(exec_access_bit));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one instruction, then compare its pulse, result and flags
    task automatic run(input logic [4:0] op, input logic [7:0] f, input logic [7:0] w, input logic [2:0] b,
        input logic dest, input logic [7:0] res, input logic [4:0] flg);
        aluf_core_model_i.issue(aluf_pkg::aluf_op_t'(op), f, w, b, dest, aluf_pkg::MODE_DIRECT, 1'b1);
        aluf_core_model_i.idle();
        #1;
        cmp(32'(result_valid), 32'h0000_0001);
        cmp(32'(alu_result), 32'(res));
        cmp(32'(flags), 32'(flg));
    endtask

    task automatic mode_chk(input logic [2:0] m, input logic [7:0] f, input logic abit, input logic [2:0] exp);
        aluf_core_model_i.issue(aluf_pkg::OP_MOVE_FILE, f, 8'h00, 3'h0, 1'b0, aluf_pkg::aluf_mode_t'(m), abit);
        aluf_core_model_i.idle();
        #1;
        cmp(32'(addr_mode), 32'(exp));
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard, far beyond the roughly 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 12'(a), 32'h0000_0000);
            cmp(rd, 32'h0000_0000);
        end
        apb(1'b1, aluf_pkg::RESULT_OFS, 32'h0000_0055);
        apb(1'b0, aluf_pkg::RESULT_OFS, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        apb(1'b1, aluf_pkg::FLAG_OFS, 32'hffff_ffff);
        apb(1'b0, aluf_pkg::FLAG_OFS, 32'h0000_0000);
        cmp(rd, 32'h0000_001f);
        apb(1'b0, 12'h010, 32'h0000_0000);
        cmp({rd[30:0], err}, 32'h0000_0001);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].f, rows[i].w, rows[i].b, 1'b0, rows[i].res, rows[i].flg);
        end
        run(5'h0a, 8'h55, 8'h00, 3'h0, 1'b1, 8'h00, 5'h1e);
        run(5'h00, 8'h00, 8'h00, 3'h0, 1'b1, 8'h00, 5'h04);
        run(5'h0c, 8'h04, 8'h00, 3'h0, 1'b1, 8'h05, 5'h05);
        apb(1'b0, aluf_pkg::FLAG_OFS, 32'h0000_0000);
        cmp(rd, 32'h0000_0005);
        run(5'h06, 8'h80, 8'hff, 3'h0, 1'b1, 8'h80, 5'h11);
        aluf_core_model_i.issue(aluf_pkg::OP_ADD_W_FILE, 8'hff, 8'h01, 3'h0, 1'b0, aluf_pkg::MODE_DIRECT, 1'b1);
        run(5'h05, 8'h00, 8'h00, 3'h0, 1'b0, 8'h01, 5'h00);
        for (int m = 0; m < 5; m++) begin
            mode_chk(3'(m), 8'h10, 1'b0, 3'(m));
        end
        apb(1'b1, aluf_pkg::CTRL_OFS, 32'h0000_0001);
        mode_chk(3'h2, 8'h5f, 1'b0, 3'h4);
        apb(1'b0, aluf_pkg::MODE_OFS, 32'h0000_0000);
        cmp(rd, 32'h0000_0004);
        mode_chk(3'h2, 8'h60, 1'b0, 3'h2);
        mode_chk(3'h2, 8'h10, 1'b1, 3'h2);
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        cmp({19'h0_0000, flags, alu_result}, 32'h0000_0000);
        mode_chk(3'h2, 8'h10, 1'b0, 3'h2);
        end_of_test();
    end
endmodule
